/* File: design/fss_defines.svh */
`ifndef FSS_DEFINES_SVH
`define FSS_DEFINES_SVH
// Register addresses held in word bits D15..D12
`define FSS_ADDR_CTRL     4'h0
`define FSS_ADDR_STEPS    4'h1
`define FSS_ADDR_DELTA_LO 4'h2
`define FSS_ADDR_DELTA_HI 4'h3
`define FSS_ADDR_FSTRT_LO 4'hC
`define FSS_ADDR_FSTRT_HI 4'hD
// Interval register is selected by D15..D14 alone
`define FSS_ADDR_IVL_HI   2'h1
// Control field positions
`define FSS_CTRL_B24      11
`define FSS_CTRL_EXTINC   5
// Interval field positions
`define FSS_IVL_BASE      13
// Word framing and reset values
`define FSS_WORD_LAST     4'hF
`define FSS_MIDSCALE      10'h200
`define FSS_CTRL_RST      12'h000
`endif

/* File: design/fss_pkg.sv */
package fss_pkg;
  typedef enum logic [1:0] {FSS_IDLE, FSS_RUN, FSS_HOLD} fss_state_type;
  typedef struct packed {
    logic [3:0]  addr;
    logic [11:0] data;
  } fss_word_type;
  typedef struct packed {
    logic [23:0] freq;
    logic [9:0]  dac;
    logic        done;
  } fss_out_type;
endpackage : fss_pkg

/* File: design/fss_top.sv */
`timescale 1ns/10ps
`include "fss_defines.svh"

module fss_top
  import fss_pkg::*;
(
  // Core clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Serial port
  input  wire logic        serial_clk,
  input  wire logic        frame_sync_n,
  input  wire logic        serial_din,
  // Control pins
  input  wire logic        scan_trig,
  input  wire logic        intr_in,
  // Outputs
  output logic [23:0]      freq_word,
  output logic [9:0]       dac_code,
  output logic             scan_done
);

  //----------------------------------------------------------------
  // Serial capture, link clock domain
  //----------------------------------------------------------------
  logic [3:0]   bit_cnt_r;
  logic [14:0]  shift_r;
  fss_word_type word_r;
  logic         word_tgl_r;
  wire          word_end = (bit_cnt_r == `FSS_WORD_LAST);
  // Core reset also clears the link count, so the first word is aligned
  wire          link_clr = frame_sync_n | ~arst_n;

  // High sync clears the count so a partial word is lost
  always_ff @(negedge serial_clk or posedge link_clr) begin
    if (link_clr) begin
      bit_cnt_r <= 4'h0;
      shift_r   <= 15'h0000;
    end else begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      shift_r   <= {shift_r[13:0], serial_din};
    end
  end

  always_ff @(negedge serial_clk or negedge arst_n) begin
    if (!arst_n) begin
      word_r     <= '0;
      word_tgl_r <= 1'b0;
    end else if (!frame_sync_n && word_end) begin
      word_r     <= {shift_r, serial_din};
      word_tgl_r <= ~word_tgl_r;
    end
  end

  //----------------------------------------------------------------
  // Crossings into the core domain
  //----------------------------------------------------------------
  logic [2:0] tgl_s_r;
  logic [2:0] trig_s_r;
  logic [2:0] intr_s_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tgl_s_r  <= 3'h0;
      trig_s_r <= 3'h0;
      intr_s_r <= 3'h0;
    end else begin
      tgl_s_r  <= {tgl_s_r[1:0], word_tgl_r};
      trig_s_r <= {trig_s_r[1:0], scan_trig};
      intr_s_r <= {intr_s_r[1:0], intr_in};
    end
  end

  wire word_new  = tgl_s_r[2] ^ tgl_s_r[1];
  wire trig_rise = trig_s_r[1] & ~trig_s_r[2];
  wire intr_rise = intr_s_r[1] & ~intr_s_r[2];

  //----------------------------------------------------------------
  // Register decode
  //----------------------------------------------------------------
  logic [11:0] ctrl_r;
  logic [11:0] steps_r;
  logic [23:0] delta_r;
  logic [23:0] fstart_r;
  logic [13:0] ivl_r;
  logic [11:0] lo_pend_r;

  wire [3:0]  waddr    = word_r.addr;
  wire [11:0] wdata    = word_r.data;
  wire        wr_ctrl  = word_new && (waddr == `FSS_ADDR_CTRL);
  wire        wr_steps = word_new && (waddr == `FSS_ADDR_STEPS);
  wire        wr_dlo   = word_new && (waddr == `FSS_ADDR_DELTA_LO);
  wire        wr_dhi   = word_new && (waddr == `FSS_ADDR_DELTA_HI);
  wire        wr_flo   = word_new && (waddr == `FSS_ADDR_FSTRT_LO);
  wire        wr_fhi   = word_new && (waddr == `FSS_ADDR_FSTRT_HI);
  wire        wr_ivl   = word_new && (waddr[3:2] == `FSS_ADDR_IVL_HI);
  wire        b24      = ctrl_r[`FSS_CTRL_B24];
  wire        ext_mode = ctrl_r[`FSS_CTRL_EXTINC];
  wire        scan_rst = wr_ctrl | intr_rise;

  // In paired mode the low half waits for the high half
  wire [11:0] dlo_nxt  = b24 ? lo_pend_r : delta_r[11:0];
  wire [11:0] flo_nxt  = b24 ? lo_pend_r : fstart_r[11:0];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r    <= `FSS_CTRL_RST;
      steps_r   <= 12'h000;
      delta_r   <= 24'h000000;
      fstart_r  <= 24'h000000;
      ivl_r     <= 14'h0000;
      lo_pend_r <= 12'h000;
    end else begin
      if (wr_ctrl)
        ctrl_r <= wdata;
      if (wr_steps)
        steps_r <= wdata;
      if (wr_ivl)
        ivl_r <= {waddr[1:0], wdata};
      if ((wr_dlo || wr_flo) && b24)
        lo_pend_r <= wdata;
      if (wr_dlo && !b24)
        delta_r[11:0] <= wdata;
      if (wr_dhi)
        delta_r <= {wdata, dlo_nxt};
      if (wr_flo && !b24)
        fstart_r[11:0] <= wdata;
      if (wr_fhi)
        fstart_r <= {wdata, flo_nxt};
    end
  end

  //----------------------------------------------------------------
  // Scan sequencer
  //----------------------------------------------------------------
  fss_state_type state_r;
  fss_state_type state_nxt;
  logic [23:0]   phase_r;
  logic [23:0]   freq_r;
  logic [11:0]   step_r;
  logic [12:0]   dwell_r;
  fss_out_type   out_r;
  fss_out_type   out_nxt;

  wire [23:0] phase_nxt  = phase_r + freq_r;
  wire        cyc_tick   = phase_nxt[23] & ~phase_r[23];
  wire        dwell_tick = ivl_r[`FSS_IVL_BASE] ? cyc_tick : 1'b1;
  wire [12:0] dwell_inc  = dwell_r + 13'h0001;
  wire        dwell_end  = dwell_tick && (dwell_inc >= ivl_r[12:0]);
  wire        last_step  = (step_r == steps_r);
  wire        adv_auto   = !ext_mode && dwell_end;
  wire        adv_ext    = ext_mode && trig_rise;
  wire        advance    = (state_r == FSS_RUN) && (adv_auto || adv_ext);
  wire        start      = (state_r == FSS_IDLE) && trig_rise;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      FSS_IDLE: begin
        if (start)
          state_nxt = FSS_RUN;
      end
      FSS_RUN: begin
        if (advance && last_step)
          state_nxt = FSS_HOLD;
      end
      FSS_HOLD: begin
        state_nxt = FSS_HOLD;
      end
      default: begin
        state_nxt = FSS_IDLE;
      end
    endcase
    if (scan_rst)
      state_nxt = FSS_IDLE;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= FSS_IDLE;
      phase_r <= 24'h000000;
      freq_r  <= 24'h000000;
      step_r  <= 12'h000;
      dwell_r <= 13'h0000;
    end else begin
      state_r <= state_nxt;
      if (scan_rst) begin
        phase_r <= 24'h000000;
        freq_r  <= 24'h000000;
      end else if (start) begin
        phase_r <= phase_nxt;
        freq_r  <= fstart_r;
      end else if (advance && !last_step) begin
        phase_r <= phase_nxt;
        freq_r  <= freq_r + delta_r;
      end else begin
        phase_r <= phase_nxt;
      end
      if (start || scan_rst) begin
        step_r  <= 12'h000;
        dwell_r <= 13'h0000;
      end else if (advance) begin
        step_r  <= step_r + 12'h001;
        dwell_r <= 13'h0000;
      end else if (state_r == FSS_RUN && dwell_tick) begin
        dwell_r <= dwell_inc;
      end
    end
  end

  //----------------------------------------------------------------
  // Output stage
  //----------------------------------------------------------------
  wire idle_nxt = (state_nxt == FSS_IDLE);

  always_comb begin
    out_nxt.freq = freq_r;
    out_nxt.dac  = idle_nxt ? `FSS_MIDSCALE : phase_r[23:14];
    out_nxt.done = (state_nxt == FSS_HOLD);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_r   <= '{freq: 24'h000000, dac: `FSS_MIDSCALE, done: 1'b0};
    end else begin
      out_r   <= out_nxt;
    end
  end

  assign freq_word = out_r.freq;
  assign dac_code  = out_r.dac;
  assign scan_done = out_r.done;

  //----------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_ctrl_reset: assert property (wr_ctrl |=> state_r == FSS_IDLE)
    else $error("control write did not reset scan");
  a_intr_reset: assert property (intr_rise |=> dac_code == `FSS_MIDSCALE)
    else $error("interrupt did not force midscale");
  a_idle_mid: assert property (state_r == FSS_IDLE && !start |=> dac_code == `FSS_MIDSCALE)
    else $error("idle output not midscale");
  a_ctrl_mid: assert property (wr_ctrl |=> dac_code == `FSS_MIDSCALE)
    else $error("control write did not force midscale");
  a_done_hold: assert property (state_r == FSS_HOLD && !scan_rst |=> scan_done)
    else $error("done flag low while holding");
  a_hold_stays: assert property (state_r == FSS_HOLD && !scan_rst |=> state_r == FSS_HOLD)
    else $error("hold left without reset");
  a_ext_step: assert property (advance && ext_mode && !scan_rst |=> step_r == $past(step_r) + 12'h001)
    else $error("external edge did not count one step");
  a_start_freq: assert property (start && !scan_rst |=> freq_r == $past(fstart_r))
    else $error("scan did not load start word");
  a_step_add: assert property (advance && !last_step && !scan_rst
      |=> freq_r == $past(freq_r) + $past(delta_r))
    else $error("step did not add delta");
  a_hold_last: assert property (state_r == FSS_HOLD && !scan_rst
      |=> $stable(freq_r))
    else $error("held frequency changed");
  a_phase_cont: assert property (!scan_rst |=> phase_r == $past(phase_nxt))
    else $error("phase accumulator jumped");
  a_ext_wait: assert property (state_r == FSS_RUN && ext_mode && !trig_rise
      && !scan_rst |=> $stable(freq_r))
    else $error("external step without trigger");
  a_auto_dwell: assert property (state_r == FSS_RUN && !ext_mode
      && !dwell_end && !scan_rst |=> $stable(freq_r))
    else $error("auto step before dwell end");
  a_word_seen: assert property ($changed(tgl_s_r[0]) |=> word_new)
    else $error("captured word not passed to core");

  // Main scenarios
  c_auto_scan: cover property (state_r == FSS_RUN && !ext_mode ##[1:200] scan_done);
  c_cycle_tick: cover property (state_r == FSS_RUN && ivl_r[`FSS_IVL_BASE] && cyc_tick);
  c_ext_scan: cover property (adv_ext && state_r == FSS_RUN ##[1:200] adv_ext);
  c_ctrl_write: cover property (wr_ctrl);
  c_intr_abort: cover property (state_r == FSS_RUN ##1 intr_rise);

endmodule : fss_top

/* File: tb/fss_host.sv */
`timescale 1ns/10ps
module fss_host (
  // Serial link
  output logic serial_clk,
  output logic frame_sync_n,
  output logic serial_din
);
  initial begin
    serial_clk   = 1'b1;
    frame_sync_n = 1'b1;
    serial_din   = 1'b0;
  end

  // ----------------------------------------
  // Frame of nbits, MSB first, 48 ns link clock only inside the frame
  // ----------------------------------------
  task automatic frame(input logic [31:0] ws, input int nbits);
    #5;
    frame_sync_n = 1'b0;
    for (int b = nbits - 1; b >= 0; b--) begin
      serial_din = ws[b];
      #24 serial_clk = 1'b0;
      #24 serial_clk = 1'b1;
    end
    #24 frame_sync_n = 1'b1;
    serial_din = ~serial_din;
  endtask : frame
endmodule : fss_host

/* File: tb/tb.sv */
`timescale 1ns/10ps
module tb;
  logic        clk;
  logic        arst_n;
  logic        scan_trig;
  logic        intr_in;
  logic        serial_clk;
  logic        frame_sync_n;
  logic        serial_din;
  logic [23:0] freq_word;
  logic [9:0]  dac_code;
  logic        scan_done;
  int          n_fail;
  int          n_compared;
  int          k;
  int          c;
  int          nst;
  logic [23:0] st;
  logic [23:0] dl;
  logic [23:0] exp_q[$];

  fss_top dut_u (.clk(clk), .arst_n(arst_n), .serial_clk(serial_clk),
    .frame_sync_n(frame_sync_n), .serial_din(serial_din), .scan_trig(scan_trig),
    .intr_in(intr_in), .freq_word(freq_word), .dac_code(dac_code), .scan_done(scan_done));
  fss_host host_u (.serial_clk(serial_clk), .frame_sync_n(frame_sync_n),
    .serial_din(serial_din));

  always #4 clk = ~clk;

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic wclk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wclk

  task automatic pulse;
    @(posedge clk) #1 scan_trig = 1'b1;
    wclk(4);
    scan_trig = 1'b0;
    wclk(4);
  endtask : pulse

  task automatic idle_chk;
    chk(dac_code, 24'h200);
    chk(freq_word, 24'h0);
    chk(scan_done, 24'h0);
  endtask : idle_chk

  // ----------------------------------------
  // Scan model: start, start+delta, ... start+N*delta
  // ----------------------------------------
  task automatic build;
    exp_q.delete();
    for (int i = 0; i <= nst; i++) exp_q.push_back(st + dl * i);
  endtask : build

  // ----------------------------------------
  // Auto scan: dwell counted in clocks, or in rises of the output MSB
  // ----------------------------------------
  task automatic auto_scan(input bit cyc);
    logic msb_q;
    int   g;
    build();
    wclk(10);
    scan_trig = 1'b1;
    foreach (exp_q[i]) begin
      c = 0;
      g = 0;
      msb_q = dac_code[9];
      while (freq_word !== exp_q[i] && g < 100) begin
        wclk(1);
        g++;
        if (!cyc || (dac_code[9] && !msb_q)) c++;
        msb_q = dac_code[9];
      end
      scan_trig = 1'b0;
      chk(freq_word, exp_q[i]);
      if (i > 0) chk(c, k);
    end
    wclk(4 * k + 4);
    chk(scan_done, 24'h1);
    chk(freq_word, exp_q[nst]);
  endtask : auto_scan

  task automatic summarize;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  initial begin
    #200000;
    n_fail++;
    summarize();
  end

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    scan_trig = 1'b0;
    intr_in = 1'b0;
    n_fail = 0;
    n_compared = 0;
    void'($urandom(14904));
    k = 2 + $urandom % 5;
    st = $urandom;
    dl = $urandom;
    nst = 3;
    wclk(8);
    arst_n = 1'b1;
    idle_chk();
    host_u.frame(16'h0000, 16);
    host_u.frame(16'h1000 | nst, 16);
    host_u.frame({4'h2, dl[11:0]}, 16);
    host_u.frame({4'h3, dl[23:12]}, 16);
    host_u.frame({4'hC, st[11:0]}, 16);
    host_u.frame({4'hD, st[23:12]}, 16);
    host_u.frame({3'b010, 13'(k)}, 16);
    host_u.frame(16'h1F, 8);
    auto_scan(1'b0);
    host_u.frame(16'h0820, 16);
    wclk(8);
    idle_chk();
    st = $urandom;
    host_u.frame({4'hC, st[11:0], 4'hD, st[23:12]}, 32);
    build();
    wclk(8);
    idle_chk();
    foreach (exp_q[i]) begin
      pulse();
      wclk(20);
      chk(freq_word, exp_q[i]);
      chk(scan_done, 24'h0);
    end
    pulse();
    chk(scan_done, 24'h1);
    pulse();
    chk(freq_word, exp_q[nst]);
    @(posedge clk) #1 intr_in = 1'b1;
    wclk(8);
    idle_chk();
    intr_in = 1'b0;
    wclk(30);
    idle_chk();
    k = 1 + $urandom % 4;
    st = 24'h400000 | ($urandom & 24'h0FFFFF);
    dl = $urandom & 24'h0FFFFF;
    host_u.frame(16'h0800, 16);
    host_u.frame({4'h2, dl[11:0], 4'h3, dl[23:12]}, 32);
    host_u.frame({4'hC, st[11:0], 4'hD, st[23:12]}, 32);
    host_u.frame({3'b011, 13'(k)}, 16);
    auto_scan(1'b1);
    summarize();
  end
endmodule : tb
